// ### src/hbs_host_port.v
`timescale 1ns/10ps
`default_nettype none
`include "hbs_defs.vh"
module hbs_host_port #(
   parameter AW = `HBS_ADDR_W
) (
   input  wire          clk_sys_in,
   input  wire          rst_n_in,
   input  wire          latch_strobe_in,
   input  wire          chip_sel_n_in,
   input  wire          write_strobe_n_in,
   input  wire          read_strobe_n_in,
   input  wire          read_write_dir_in,
   input  wire          data_strobe_n_in,
   input  wire [AW-1:0] sep_addr_in,
   input  wire [7:0]    ad_in,
   output reg  [7:0]    ad_out,
   output reg  [7:0]    ad_oe_out,
   output reg  [1:0]    bus_style_out,
   output wire [7:0]    common_config_out,
   output wire [7:0]    channel_vector_mask_out,
   output wire          outputs_enabled_out
);
   // ----------------------------------------
   // bus style selection
   // ----------------------------------------
   reg          ale_prev_reg;
   reg          ale_seen_reg;
   reg          mux_lock_reg;
   reg [AW-1:0] mux_addr_reg;
   reg          strb_prev_reg;
   reg [7:0]    cfg_reg;
   reg [7:0]    vmask_reg;
   reg [7:0]    acmp_reg;
   reg          configured_reg;
   reg [1:0]    rd_state_reg;
   reg [1:0]    rd_state_next;
   reg [7:0]    fixed_rd_reg;
   reg          fixed_hit_reg;
   reg          vpos_reg;

   // read strobe tracking states
   localparam RD_IDLE  = 2'b00;
   localparam RD_WAIT  = 2'b01;
   localparam RD_DRIVE = 2'b10;

   // the first cycle after reset only records the level, so no edge is seen out of reset
   wire ale_edge = ale_seen_reg && (latch_strobe_in != ale_prev_reg);
   wire mux_now  = mux_lock_reg | ale_edge;

   function [1:0] style_of;
      input mux;
      input level;
      begin
         if (mux)
            style_of = `HBS_STYLE_MUX;
         else if (level)
            style_of = `HBS_STYLE_DIRSTB;
         else
            style_of = `HBS_STYLE_SPLIT;
      end
   endfunction

   // an edge switches the style in the same cycle, before the lock flop is set
   always @*
   begin
      bus_style_out = style_of(mux_now, latch_strobe_in);
   end

   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         ale_prev_reg <= 1'b0;
         ale_seen_reg <= 1'b0;
         mux_lock_reg <= 1'b0;
         mux_addr_reg <= {AW{1'b0}};
      end
      else
      begin
         ale_prev_reg <= latch_strobe_in;
         ale_seen_reg <= 1'b1;
         if (ale_edge)
            mux_lock_reg <= 1'b1;
         if (ale_seen_reg && ale_prev_reg && !latch_strobe_in)
            mux_addr_reg <= ad_in[AW-1:0];
      end
   end

   // ----------------------------------------
   // access decode per style
   // ----------------------------------------
   wire          cs      = !chip_sel_n_in;
   wire [AW-1:0] addr    = mux_lock_reg ? mux_addr_reg : sep_addr_in;
   wire          dir_style = (bus_style_out == `HBS_STYLE_DIRSTB);
   wire          wr_act  = cs && (dir_style ? (!data_strobe_n_in && !read_write_dir_in) : !write_strobe_n_in);
   wire          rd_act  = cs && (dir_style ? (!data_strobe_n_in && read_write_dir_in) : !read_strobe_n_in);
   // writes take effect once per strobe, on its first cycle
   wire          wr_pulse = wr_act && !strb_prev_reg;

   function is_fixed;
      input [AW-1:0] a;
      begin
         is_fixed = (a == `HBS_OFS_ADDR_CMP) || (a == `HBS_OFS_COMMON_CFG) ||
                    (a == `HBS_OFS_VEC_MASK) || (a == `HBS_OFS_VEC_STATUS);
      end
   endfunction

   // ----------------------------------------
   // address helpers
   // ----------------------------------------
   // field offset inside a channel block
   function [3:0] field_of;
      input [AW-1:0] a;
      reg   [AW-1:0] r;
      begin
         r        = a % `HBS_CH_STRIDE;
         field_of = r[3:0];
      end
   endfunction

   // vector status drives only its nibble, the other half floats
   function [7:0] drive_mask;
      input [AW-1:0] a;
      input          vpos;
      begin
         if (a != `HBS_OFS_VEC_STATUS)
            drive_mask = 8'hff;
         else if (vpos)
            drive_mask = 8'hf0;
         else
            drive_mask = 8'h0f;
      end
   endfunction

   function [7:0] fixed_read;
      input [AW-1:0] a;
      input [7:0]    acmp;
      input [7:0]    cfg;
      input [7:0]    vmask;
      begin
         case (a)
            `HBS_OFS_ADDR_CMP   : fixed_read = acmp;
            `HBS_OFS_COMMON_CFG : fixed_read = cfg;
            `HBS_OFS_VEC_MASK   : fixed_read = vmask;
            default             : fixed_read = `HBS_RST_ZERO; // no vector pending
         endcase
      end
   endfunction

   // ----------------------------------------
   // read strobe tracking: drive starts on the third strobe cycle
   // ----------------------------------------
   always @*
   begin
      rd_state_next = RD_IDLE;
      case (rd_state_reg)
         RD_IDLE :
         begin
            if (rd_act)
               rd_state_next = RD_WAIT;
         end
         RD_WAIT :
         begin
            if (rd_act)
               rd_state_next = RD_DRIVE;
         end
         RD_DRIVE :
         begin
            if (rd_act)
               rd_state_next = RD_DRIVE;
         end
         default :
         begin
            rd_state_next = RD_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // common registers and reset state
   // ----------------------------------------
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         strb_prev_reg  <= 1'b0;
         cfg_reg        <= `HBS_RST_ZERO;
         vmask_reg      <= `HBS_RST_ZERO;
         acmp_reg       <= `HBS_RST_ZERO;
         configured_reg <= 1'b0;
         rd_state_reg   <= RD_IDLE;
         fixed_rd_reg   <= `HBS_RST_ZERO;
         fixed_hit_reg  <= 1'b0;
         vpos_reg       <= 1'b0;
      end
      else
      begin
         strb_prev_reg <= wr_act | rd_act;
         rd_state_reg  <= rd_state_next;
         vpos_reg      <= cfg_reg[`HBS_CFG_VEC_POS_BIT];
         fixed_hit_reg <= is_fixed(addr);
         fixed_rd_reg  <= fixed_read(addr, acmp_reg, cfg_reg, vmask_reg);
         if (wr_pulse)
         begin
            configured_reg <= 1'b1;
            case (addr)
               `HBS_OFS_ADDR_CMP   : acmp_reg  <= ad_in;
               `HBS_OFS_COMMON_CFG : cfg_reg   <= ad_in;
               `HBS_OFS_VEC_MASK   : vmask_reg <= ad_in;
               default             : ; // channel registers live in the memory
            endcase
         end
      end
   end

   // ----------------------------------------
   // per-channel registers in memory, loaded by a walk after reset is released
   // ----------------------------------------
   reg [AW-1:0] clr_addr_reg;
   reg [AW-1:0] clr_addr_next;
   reg          clr_busy_reg;
   reg          clr_busy_next;
   wire [7:0]   mem_rd;
   wire [3:0]   ch_field = field_of(clr_addr_reg);
   wire [7:0]   clr_val  = (ch_field == `HBS_OFS_CH_STATUS) ? `HBS_RST_CH_STATUS : `HBS_RST_ZERO;

   // host writes to channel registers are lost while the walk runs; it ends 128 cycles after reset
   always @*
   begin
      clr_addr_next = clr_addr_reg;
      clr_busy_next = clr_busy_reg;
      if (clr_busy_reg)
      begin
         clr_addr_next = clr_addr_reg + 1'b1;
         if (&clr_addr_reg)
            clr_busy_next = 1'b0;
      end
   end

   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         clr_addr_reg <= {AW{1'b0}};
         clr_busy_reg <= 1'b1;
      end
      else
      begin
         clr_addr_reg <= clr_addr_next;
         clr_busy_reg <= clr_busy_next;
      end
   end

   // ----------------------------------------
   // memory port select
   // ----------------------------------------
   wire          mem_we = clr_busy_reg | (wr_pulse && !is_fixed(addr));
   wire [AW-1:0] mem_wa = clr_busy_reg ? clr_addr_reg : addr;
   wire [7:0]    mem_wd = clr_busy_reg ? clr_val : ad_in;

   hbs_reg_mem #(
      .AW (AW)
   ) u_mem (
      .clk_sys_in  (clk_sys_in),
      .wr_en_in    (mem_we),
      .wr_addr_in  (mem_wa),
      .wr_data_in  (mem_wd),
      .rd_addr_in  (addr),
      .rd_data_out (mem_rd)
   );

   // ----------------------------------------
   // read data drive, floating until configured
   // ----------------------------------------
   always @(posedge clk_sys_in)
   begin
      if (!rst_n_in)
      begin
         ad_out    <= 8'h00;
         ad_oe_out <= 8'h00;
      end
      else
      begin
         ad_out    <= fixed_hit_reg ? fixed_rd_reg : mem_rd;
         // reads float until the first write
         if ((rd_state_reg != RD_IDLE) && rd_act && configured_reg)
            ad_oe_out <= drive_mask(addr, vpos_reg);
         else
            ad_oe_out <= 8'h00;
      end
   end

   assign common_config_out       = cfg_reg;
   assign channel_vector_mask_out = vmask_reg;
   assign outputs_enabled_out     = configured_reg;
endmodule
`default_nettype wire

// ### src/hbs_defs.vh
`ifndef HBS_DEFS_VH
`define HBS_DEFS_VH
`define HBS_STYLE_DIRSTB     2'h0
`define HBS_STYLE_SPLIT      2'h1
`define HBS_STYLE_MUX        2'h2
`define HBS_ADDR_W           7
`define HBS_NUM_CH           4
// common register offsets
`define HBS_OFS_ADDR_CMP     7'h30
`define HBS_OFS_COMMON_CFG   7'h31
`define HBS_OFS_VEC_MASK     7'h32
`define HBS_OFS_VEC_STATUS   7'h36
// per-channel block: base = ch * stride
`define HBS_CH_STRIDE        7'h0c
`define HBS_OFS_EV_STATUS    4'h0
`define HBS_OFS_EV_MASK      4'h1
`define HBS_OFS_CH_STATUS    4'h2
`define HBS_OFS_CH_CMD       4'h3
`define HBS_OFS_CH_MODE      4'h4
`define HBS_OFS_RX_COUNT     4'h5
`define HBS_OFS_SLOT_SEL     4'h6
// reset values
`define HBS_RST_ZERO         8'h00
`define HBS_RST_CH_STATUS    8'h50
// common config field: vector position select
`define HBS_CFG_VEC_POS_BIT  4
`endif

// ### src/hbs_reg_mem.v
`timescale 1ns/10ps
`default_nettype none
module hbs_reg_mem #(
   parameter AW = 7
) (
   input  wire          clk_sys_in,
   input  wire          wr_en_in,
   input  wire [AW-1:0] wr_addr_in,
   input  wire [7:0]    wr_data_in,
   input  wire [AW-1:0] rd_addr_in,
   output reg  [7:0]    rd_data_out
);
   // ----------------------------------------
   // plain storage, registered read
   // ----------------------------------------
   reg [7:0] mem_reg [0:(1<<AW)-1];

   always @(posedge clk_sys_in)
   begin
      if (wr_en_in)
      begin
         mem_reg[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_reg[rd_addr_in];
   end
endmodule
`default_nettype wire

// ### test/hbs_host_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
module hbs_host_port_properties #(
   parameter AW = 7
) (
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   input  wire logic          latch_strobe_in,
   input  wire logic          chip_sel_n_in,
   input  wire logic          write_strobe_n_in,
   input  wire logic          read_strobe_n_in,
   input  wire logic          read_write_dir_in,
   input  wire logic          data_strobe_n_in,
   input  wire logic [AW-1:0] sep_addr_in,
   input  wire logic [7:0]    ad_in,
   input  wire logic [7:0]    ad_out,
   input  wire logic [7:0]    ad_oe_out,
   input  wire logic [1:0]    bus_style_out,
   input  wire logic [7:0]    common_config_out,
   input  wire logic [7:0]    channel_vector_mask_out,
   input  wire logic          outputs_enabled_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_rel;
      rst_n_in && !$past(rst_n_in);
   endsequence
   sequence s_strobe_read;
      (!chip_sel_n_in && !read_strobe_n_in && outputs_enabled_out && bus_style_out != 2'h0) [*3];
   endsequence
   a_edge_mux: assert property (
      rst_n_in && $past(rst_n_in) && $past(rst_n_in, 2) && $past(rst_n_in, 3) && $changed(latch_strobe_in)
      |-> ##[0:2] bus_style_out == 2'h2) else $error("latch edge kept old style");
   a_mux_sticky: assert property (bus_style_out == 2'h2 |=> bus_style_out == 2'h2)
      else $error("mux style lost");
   a_style_level: assert property (s_rel |-> bus_style_out == (latch_strobe_in ? 2'h0 : 2'h1))
      else $error("wrong style from level");
   a_reset_float: assert property (s_rel |-> ad_oe_out == 8'h00) else $error("drive after reset");
   a_reset_cfg: assert property (s_rel |-> common_config_out == 8'h00) else $error("cfg not 00");
   a_reset_mask: assert property (s_rel |-> channel_vector_mask_out == 8'h00)
      else $error("mask not 00");
   a_float_unset: assert property (!outputs_enabled_out |-> ad_oe_out == 8'h00)
      else $error("drive before write");
   a_enable_held: assert property (outputs_enabled_out |=> outputs_enabled_out)
      else $error("enable dropped");
   a_read_drive: assert property (s_strobe_read |-> ad_oe_out != 8'h00)
      else $error("read not driven");
endmodule
bind hbs_host_port hbs_host_port_properties #(.AW(AW)) chk_u (
   .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .latch_strobe_in(latch_strobe_in),
   .chip_sel_n_in(chip_sel_n_in), .write_strobe_n_in(write_strobe_n_in), .read_strobe_n_in(read_strobe_n_in),
   .read_write_dir_in(read_write_dir_in), .data_strobe_n_in(data_strobe_n_in), .sep_addr_in(sep_addr_in),
   .ad_in(ad_in), .ad_out(ad_out), .ad_oe_out(ad_oe_out), .bus_style_out(bus_style_out),
   .common_config_out(common_config_out), .channel_vector_mask_out(channel_vector_mask_out),
   .outputs_enabled_out(outputs_enabled_out));
`default_nettype wire

// ### test/hbs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hbs_host_model (
   input  wire logic       clk_sys_in,
   input  wire logic [7:0] ad_out,
   input  wire logic [7:0] ad_oe_out,
   output logic            latch_out,
   output logic            cs_n_out,
   output logic            wr_n_out,
   output logic            rd_n_out,
   output logic            rw_out,
   output logic            ds_n_out,
   output logic [6:0]      addr_out,
   output logic [7:0]      ad_lvl_out
);
   logic [7:0] val;
   logic [7:0] last;
   logic       drv;
   logic [7:0] oe_seen;
   // undriven bits toggle so a stale value never passes
   always_comb ad_lvl_out = drv ? val : ((ad_oe_out & ad_out) | (~ad_oe_out & ~last));
   always @(negedge clk_sys_in) last <= ad_lvl_out;
   initial
   begin
      latch_out = 1'b1;
      {cs_n_out, wr_n_out, rd_n_out, rw_out, ds_n_out} = 5'h1f;
      addr_out = 7'h00;
      {drv, val, last} = 17'h00000;
   end
   task automatic acc(input logic [1:0] st, input logic rd, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      if (st == 2'h2)
      begin
         latch_out = 1'b1;
         drv = 1'b1;
         val = {1'b0, a};
         @(negedge clk_sys_in);
         latch_out = 1'b0;
         repeat (2) @(negedge clk_sys_in);
      end
      addr_out = a;
      drv = !rd;
      val = d;
      cs_n_out = 1'b0;
      rw_out = rd;
      ds_n_out = (st != 2'h0);
      rd_n_out = !(rd && st != 2'h0);
      wr_n_out = !(!rd && st != 2'h0);
      repeat (3) @(negedge clk_sys_in);
      q = ad_lvl_out;
      oe_seen = ad_oe_out;
      {cs_n_out, wr_n_out, rd_n_out, rw_out, ds_n_out} = 5'h1f;
      drv = 1'b0;
      @(negedge clk_sys_in);
   endtask
endmodule
`default_nettype wire

// ### test/host_bus_select_and_reset_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_select_and_reset_tb_top;
   logic       clk_sys_in = 1'b0;
   logic       rst_n_in = 1'b0;
   wire  [7:0] ad_o, ad_oe, ad_lvl, cfg, vmask;
   wire  [6:0] addr;
   wire  [1:0] style;
   wire        latch, cs_n, wr_n, rd_n, rw, ds_n, en;
   logic [7:0] q;
   int         fails = 0;
   int         n_tests = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   hbs_host_model host (.clk_sys_in(clk_sys_in), .ad_out(ad_o), .ad_oe_out(ad_oe), .latch_out(latch),
      .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n), .rw_out(rw), .ds_n_out(ds_n), .addr_out(addr),
      .ad_lvl_out(ad_lvl));
   hbs_host_port dut_u (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .latch_strobe_in(latch),
      .chip_sel_n_in(cs_n), .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n), .read_write_dir_in(rw),
      .data_strobe_n_in(ds_n), .sep_addr_in(addr), .ad_in(ad_lvl), .ad_out(ad_o), .ad_oe_out(ad_oe),
      .bus_style_out(style), .common_config_out(cfg), .channel_vector_mask_out(vmask),
      .outputs_enabled_out(en));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic reset_dut;
      rst_n_in = 1'b0;
      repeat (5) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      @(negedge clk_sys_in);
   endtask
   initial
   begin
      #100000;
      fails++;
      print_verdict;
   end
   initial
   begin
      reset_dut;
      chk({6'h00, style}, 8'h00);
      repeat (130) @(negedge clk_sys_in);
      host.acc(2'h0, 1'b1, 7'h31, 8'h00, q);
      chk(host.oe_seen, 8'h00);
      host.acc(2'h0, 1'b0, 7'h30, 8'h00, q);
      for (int c = 0; c < 4; c++)
         for (int f = 0; f < 7; f++)
         begin
            host.acc(2'h0, 1'b1, 7'(c * 12 + f), 8'h00, q);
            chk(q, (f == 2) ? 8'h50 : 8'h00);
         end
      for (int i = 0; i < 3; i++)
      begin
         host.acc(2'h0, 1'b1, 7'(48 + i), 8'h00, q);
         chk(q, 8'h00);
      end
      host.acc(2'h0, 1'b1, 7'h36, 8'h00, q);
      chk(host.oe_seen, 8'h0f);
      chk(q & 8'h0f, 8'h00);
      $display("test reset values done");
      host.latch_out = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      chk({6'h00, style}, 8'h02);
      host.acc(2'h2, 1'b0, 7'h31, 8'ha5, q);
      chk(cfg, 8'ha5);
      host.acc(2'h2, 1'b1, 7'h31, 8'h00, q);
      chk(q, 8'ha5);
      host.acc(2'h2, 1'b0, 7'h32, 8'h3c, q);
      chk(vmask, 8'h3c);
      repeat (20) @(negedge clk_sys_in);
      chk({6'h00, style}, 8'h02);
      $display("test multiplexed done");
      reset_dut;
      chk({6'h00, style}, 8'h01);
      chk(cfg, 8'h00);
      chk(vmask, 8'h00);
      repeat (130) @(negedge clk_sys_in);
      host.acc(2'h1, 1'b0, 7'h31, 8'h5a, q);
      host.acc(2'h1, 1'b0, 7'h04, 8'h01, q);
      host.acc(2'h1, 1'b1, 7'h04, 8'h00, q);
      chk(q, 8'h01);
      host.acc(2'h1, 1'b1, 7'h36, 8'h00, q);
      chk(host.oe_seen, 8'hf0);
      $display("test split strobes done");
      print_verdict;
   end
endmodule
`default_nettype wire
